/* hw/irq_vec_pkg.sv */
package irq_vec_pkg;
   localparam int NUM_SRC = 18;
   localparam int NUM_GRP = 6;
   localparam int NUM_PER = 9;
   localparam int PMASK_SEL_LSB = 28;
   localparam logic [3:0] PMASK_SEL_ALL = 4'hf;
   localparam logic [11:0] ADDR_ENABLE  = 12'h000;
   localparam logic [11:0] ADDR_FLAG    = 12'h004;
   localparam logic [11:0] ADDR_PRIO    = 12'h008;
   localparam logic [11:0] ADDR_STATUS  = 12'h00c;
   localparam logic [11:0] ADDR_PMASK   = 12'h010;
   localparam logic [11:0] ADDR_IRQSTAT = 12'h014;
   localparam logic [11:0] ADDR_IRQMASK = 12'h018;
   localparam logic [11:0] ADDR_SWSET   = 12'h01c;
   localparam int GLOBAL_EN_BIT = 31;
   localparam logic [17:0] AUTO_CLEAR_MASK = 18'h01e0f;
   localparam logic [15:0] VEC_STEP = 16'h0008;
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam int SRC_SERIAL1_RX = 3;
   localparam int SRC_PORT2      = 6;
   localparam int SRC_DMA        = 8;
   localparam int SRC_TIMER_TWO  = 10;
   localparam int SRC_PORT0      = 13;
   localparam int SRC_SERIAL1_TX = 14;
   localparam int SRC_WATCHDOG   = 17;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ  = 3'b010,
      ST_ACK  = 3'b100
   } vec_state_e;
endpackage

/* hw/event_merge.sv */
`timescale 1ns/100ps
module event_merge
   import irq_vec_pkg::*;
#(
   parameter int N = 8
)
(
   input  wire logic [N-1:0] events_i,
   input  wire logic [N-1:0] mask_i,
   output wire logic         req_o
);
   assign req_o = |(events_i & mask_i);
endmodule

/* hw/irq_vec_ctrl.sv */
// The register offsets and the APB slave port were left to the implementer.
`timescale 1ns/100ps
module irq_vec_ctrl
   import irq_vec_pkg::*;
#(
   parameter int EVW = 8
)
(
   input  wire logic                 CLK_SYS_I,
   input  wire logic                 RST_N_I,
   input  wire logic [11:0]          PADDR_I,
   input  wire logic                 PSEL_I,
   input  wire logic                 PENABLE_I,
   input  wire logic                 PWRITE_I,
   input  wire logic [31:0]          PWDATA_I,
   output logic      [31:0]          PRDATA_O,
   output wire logic                 PREADY_O,
   output wire logic                 PSLVERR_O,
   input  wire logic [NUM_SRC-1:0]   SINGLE_EVENT_I,
   input  wire logic [EVW-1:0]       PORT0_EVENT_I,
   input  wire logic                 USB_RESUME_I,
   input  wire logic [EVW-1:0]       PORT1_EVENT_I,
   input  wire logic [EVW-1:0]       PORT2_EVENT_I,
   input  wire logic                 USB_PENDING_I,
   input  wire logic [EVW-1:0]       DMA_EVENT_I,
   input  wire logic [EVW-1:0]       TIMER_ONE_EVENT_I,
   input  wire logic [EVW-1:0]       TIMER_TWO_EVENT_I,
   input  wire logic [EVW-1:0]       TIMER_THREE_EVENT_I,
   input  wire logic [EVW-1:0]       TIMER_FOUR_EVENT_I,
   input  wire logic [EVW-1:0]       RADIO_EVENT_I,
   input  wire logic                 AUDIO_RX_I,
   input  wire logic                 AUDIO_TX_I,
   input  wire logic                 WATCHDOG_OVF_I,
   input  wire logic                 WATCHDOG_TIMER_MODE_I,
   input  wire logic                 CPU_ACK_I,
   output wire logic                 CPU_IRQ_O,
   output logic      [15:0]          CPU_VECTOR_O,
   output logic      [4:0]           CPU_SRC_O,
   output wire logic                 IRQ_O
);
   logic [NUM_SRC-1:0]   enable_reg;
   logic                 global_int_enable_reg;
   logic [NUM_SRC-1:0]   flag_reg;
   logic [NUM_SRC-1:0]   flag_next;
   logic [2*NUM_GRP-1:0] prio_reg;
   logic [NUM_PER*EVW-1:0] pmask_reg;
   logic [3:0]           pmask_sel_reg;
   logic [3:0]           pmask_sel;
   logic                 pmask_wr;
   logic [EVW-1:0]       pmask_rd;
   logic [2:0]           irqstat_reg;
   logic [2:0]           irqmask_reg;
   logic [NUM_SRC-1:0]   raw_req;
   logic [NUM_SRC-1:0]   raw_q_reg;
   logic [NUM_SRC-1:0]   rise;
   logic [NUM_SRC-1:0]   sw_set;
   logic [NUM_SRC-1:0]   ack_clr;
   logic [NUM_SRC-1:0]   active;
   logic [NUM_SRC-1:0]   w1c_flag;
   logic                 found;
   logic [4:0]           win_src;
   logic [1:0]           win_lvl;
   logic [1:0]           lvl;
   logic [NUM_PER-1:0]   multi_req;
   logic [2:0]           irq_events;
   logic                 wr_en;
   logic                 rd_en;
   logic                 addr_ok;
   vec_state_e           state_reg;
   vec_state_e           state_next;

   // Peripheral event sets: index 0 port0 .. 7 timer four, 8 radio
   event_merge #(.N(EVW)) u_port0
   (
      .events_i ({PORT0_EVENT_I[EVW-1] | USB_RESUME_I,
                  PORT0_EVENT_I[EVW-2:0]}),
      .mask_i   (pmask_reg[0*EVW +: EVW]),
      .req_o    (multi_req[0])
   );
   event_merge #(.N(EVW)) u_port1
   (
      .events_i (PORT1_EVENT_I),
      .mask_i   (pmask_reg[1*EVW +: EVW]),
      .req_o    (multi_req[1])
   );
   event_merge #(.N(EVW)) u_port2
   (
      .events_i (PORT2_EVENT_I),
      .mask_i   (pmask_reg[2*EVW +: EVW]),
      .req_o    (multi_req[2])
   );
   event_merge #(.N(EVW)) u_dma
   (
      .events_i (DMA_EVENT_I),
      .mask_i   (pmask_reg[3*EVW +: EVW]),
      .req_o    (multi_req[3])
   );
   event_merge #(.N(EVW)) u_tim1
   (
      .events_i (TIMER_ONE_EVENT_I),
      .mask_i   (pmask_reg[4*EVW +: EVW]),
      .req_o    (multi_req[4])
   );
   event_merge #(.N(EVW)) u_tim2
   (
      .events_i (TIMER_TWO_EVENT_I),
      .mask_i   (pmask_reg[5*EVW +: EVW]),
      .req_o    (multi_req[5])
   );
   event_merge #(.N(EVW)) u_tim3
   (
      .events_i (TIMER_THREE_EVENT_I),
      .mask_i   (pmask_reg[6*EVW +: EVW]),
      .req_o    (multi_req[6])
   );
   event_merge #(.N(EVW)) u_tim4
   (
      .events_i (TIMER_FOUR_EVENT_I),
      .mask_i   (pmask_reg[7*EVW +: EVW]),
      .req_o    (multi_req[7])
   );
   event_merge #(.N(EVW)) u_radio
   (
      .events_i (RADIO_EVENT_I),
      .mask_i   (pmask_reg[8*EVW +: EVW]),
      .req_o    (multi_req[8])
   );

   // Source map; sources 0-2, 4, 5 and 7 come straight from SINGLE_EVENT_I, 3 and 14 also take the audio lines
   always_comb
   begin
      raw_req = SINGLE_EVENT_I;
      raw_req[0]  = SINGLE_EVENT_I[0];
      raw_req[SRC_SERIAL1_RX] = SINGLE_EVENT_I[SRC_SERIAL1_RX]
                                | AUDIO_RX_I;
      raw_req[SRC_PORT2] = multi_req[2] | USB_PENDING_I;
      raw_req[SRC_DMA]   = multi_req[3];
      raw_req[9]  = multi_req[4];
      raw_req[SRC_TIMER_TWO] = multi_req[5];
      raw_req[11] = multi_req[6];
      raw_req[12] = multi_req[7];
      raw_req[SRC_PORT0] = multi_req[0];
      raw_req[SRC_SERIAL1_TX] = SINGLE_EVENT_I[SRC_SERIAL1_TX]
                                | AUDIO_TX_I;
      raw_req[15] = multi_req[1];
      raw_req[16] = multi_req[8];
      raw_req[SRC_WATCHDOG] = WATCHDOG_OVF_I
                              & WATCHDOG_TIMER_MODE_I;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         raw_q_reg <= '0;
      else
         raw_q_reg <= raw_req;
   end

   assign rise = raw_req & ~raw_q_reg;

   // APB slave, zero wait states
   assign addr_ok   = (PADDR_I[11:5] == 7'h00) && (PADDR_I[1:0] == 2'b00);
   assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I;
   assign rd_en     = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_ok;

   assign sw_set   = (wr_en && PADDR_I == ADDR_SWSET) ?
                     PWDATA_I[NUM_SRC-1:0] : '0;
   assign w1c_flag = (wr_en && PADDR_I == ADDR_FLAG) ?
                     PWDATA_I[NUM_SRC-1:0] : '0;

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         enable_reg            <= '0;
         global_int_enable_reg <= 1'b0;
         prio_reg              <= '0;
         irqmask_reg           <= '0;
      end
      else if (wr_en)
      begin
         unique case (PADDR_I)
            ADDR_ENABLE:
            begin
               enable_reg            <= PWDATA_I[NUM_SRC-1:0];
               global_int_enable_reg <= PWDATA_I[GLOBAL_EN_BIT];
            end
            ADDR_PRIO:    prio_reg    <= PWDATA_I[2*NUM_GRP-1:0];
            ADDR_IRQMASK: irqmask_reg <= PWDATA_I[2:0];
            default:      ;
         endcase
      end
   end

   // Event masks: PWDATA_I[31:28] names the peripheral, all ones
   // names every one at once, and the low EVW bits are its mask
   assign pmask_wr  = wr_en && (PADDR_I == ADDR_PMASK);
   assign pmask_sel = PWDATA_I[PMASK_SEL_LSB +: 4];

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         pmask_reg     <= '0;
         pmask_sel_reg <= '0;
      end
      else if (pmask_wr)
      begin
         pmask_sel_reg <= pmask_sel;
         for (int p = 0; p < NUM_PER; p++)
         begin
            if (pmask_sel == PMASK_SEL_ALL || pmask_sel == 4'(p))
               pmask_reg[p*EVW +: EVW] <= PWDATA_I[EVW-1:0];
         end
      end
   end

   // Read view of the mask last named; peripheral 0 when all or none is
   always_comb
   begin
      pmask_rd = pmask_reg[0 +: EVW];
      for (int p = 0; p < NUM_PER; p++)
      begin
         if (pmask_sel_reg == 4'(p))
            pmask_rd = pmask_reg[p*EVW +: EVW];
      end
   end

   // Flags: hardware set beats any clear in the same cycle
   always_comb
   begin
      flag_next = (flag_reg & ~w1c_flag & ~ack_clr) | rise | sw_set;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         flag_reg <= '0;
      else
         flag_reg <= flag_next;
   end

   // Arbitration: highest level, then lowest source number
   assign active = flag_reg & enable_reg;

   always_comb
   begin
      found   = 1'b0;
      win_src = '0;
      win_lvl = '0;
      lvl     = '0;
      for (int i = 0; i < NUM_SRC; i++)
      begin
         lvl = prio_reg[2*(i % NUM_GRP) +: 2];
         if (active[i] && (!found || lvl > win_lvl))
         begin
            found   = 1'b1;
            win_src = 5'(i);
            win_lvl = lvl;
         end
      end
   end

   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         ST_IDLE: if (found && global_int_enable_reg) state_next = ST_REQ;
         ST_REQ:
         begin
            if (!global_int_enable_reg || !active[CPU_SRC_O])
               state_next = ST_IDLE;
            else if (CPU_ACK_I)
               state_next = ST_ACK;
         end
         ST_ACK:  state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
      begin
         CPU_VECTOR_O <= VEC_BASE;
         CPU_SRC_O    <= '0;
      end
      else if (state_reg != ST_REQ)
      begin
         CPU_VECTOR_O <= VEC_BASE + VEC_STEP * 16'(win_src);
         CPU_SRC_O    <= win_src;
      end
   end

   // Request drops at once if its source is cleared or disabled
   assign CPU_IRQ_O = (state_reg == ST_REQ) && global_int_enable_reg
                      && active[CPU_SRC_O];

   always_comb
   begin
      ack_clr = '0;
      if (CPU_IRQ_O && CPU_ACK_I)
         ack_clr[CPU_SRC_O] = AUTO_CLEAR_MASK[CPU_SRC_O];
   end

   // Block interrupt: request raised, vector taken, bus error
   assign irq_events = {PSLVERR_O, CPU_IRQ_O & CPU_ACK_I,
                        |(rise & enable_reg)};

   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         irqstat_reg <= '0;
      else if (wr_en && PADDR_I == ADDR_IRQSTAT)
         irqstat_reg <= (irqstat_reg & ~PWDATA_I[2:0]) | irq_events;
      else
         irqstat_reg <= irqstat_reg | irq_events;
   end

   assign IRQ_O = |(irqstat_reg & irqmask_reg);

   // Read data is caught in the setup cycle and stands through the access
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         PRDATA_O <= RST_ZERO;
      else if (rd_en)
      begin
         PRDATA_O <= RST_ZERO;
         unique case (PADDR_I)
            ADDR_ENABLE:
            begin
               PRDATA_O[NUM_SRC-1:0]   <= enable_reg;
               PRDATA_O[GLOBAL_EN_BIT] <= global_int_enable_reg;
            end
            ADDR_FLAG:    PRDATA_O[NUM_SRC-1:0]   <= flag_reg;
            ADDR_PRIO:    PRDATA_O[2*NUM_GRP-1:0] <= prio_reg;
            ADDR_STATUS:  PRDATA_O <= {16'h0000, found, state_reg,
                                       win_lvl, CPU_IRQ_O, 4'h0, win_src};
            ADDR_PMASK:
            begin
               PRDATA_O[PMASK_SEL_LSB +: 4] <= pmask_sel_reg;
               PRDATA_O[EVW-1:0]            <= pmask_rd;
            end
            ADDR_IRQSTAT: PRDATA_O[2:0] <= irqstat_reg;
            ADDR_IRQMASK: PRDATA_O[2:0] <= irqmask_reg;
            default:      PRDATA_O <= RST_ZERO;
         endcase
      end
   end
endmodule

/* dv/irq_vec_chk.sv */
`timescale 1ns/100ps
module irq_vec_chk
   import irq_vec_pkg::*;
(
   input wire logic        CLK_SYS_I,
   input wire logic        RST_N_I,
   input wire logic [11:0] PADDR_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic        CPU_ACK_I,
   input wire logic        CPU_IRQ_O,
   input wire logic [15:0] CPU_VECTOR_O,
   input wire logic [4:0]  CPU_SRC_O
);
   logic [31:0] en_reg;
   logic        acc;
   logic        mapped;
   assign acc = PSEL_I && PENABLE_I;
   assign mapped = PADDR_I[11:5] == 7'h00 && PADDR_I[1:0] == 2'h0;
   // Shadow of the enable register, to judge what may be requested
   always_ff @(posedge CLK_SYS_I)
   begin
      if (!RST_N_I)
         en_reg <= RST_ZERO;
      else if (acc && PWRITE_I && PADDR_I == ADDR_ENABLE)
         en_reg <= PWDATA_I;
   end
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_taken;
      CPU_IRQ_O && CPU_ACK_I;
   endsequence
   property p_ready; PREADY_O; endproperty
   property p_err; PSLVERR_O |-> acc && !mapped; endproperty
   property p_no_err; acc && mapped |-> !PSLVERR_O; endproperty
   property p_vec;
      CPU_IRQ_O |-> CPU_VECTOR_O == {8'h00, CPU_SRC_O, 3'b011};
   endproperty
   property p_range; CPU_IRQ_O |-> CPU_SRC_O < 5'd18; endproperty
   property p_global; CPU_IRQ_O |-> en_reg[GLOBAL_EN_BIT]; endproperty
   property p_src_en; CPU_IRQ_O |-> en_reg[CPU_SRC_O]; endproperty
   property p_reset;
      $rose(RST_N_I) |-> CPU_VECTOR_O == VEC_BASE && !CPU_IRQ_O;
   endproperty
   property p_ack; s_taken |=> !CPU_IRQ_O; endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   a_err: assert property (p_err) else $error("error without cause");
   a_no_err: assert property (p_no_err) else $error("error on mapped");
   a_vec: assert property (p_vec) else $error("bad vector");
   a_range: assert property (p_range) else $error("bad source");
   a_global: assert property (p_global) else $error("global off");
   a_src_en: assert property (p_src_en) else $error("source off");
   a_reset: assert property (p_reset) else $error("reset state");
   a_ack: assert property (p_ack) else $error("request after ack");
endmodule

bind irq_vec_ctrl irq_vec_chk irq_vec_chk_inst (.CLK_SYS_I(CLK_SYS_I),
   .RST_N_I(RST_N_I), .PADDR_I(PADDR_I), .PSEL_I(PSEL_I),
   .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PWDATA_I(PWDATA_I),
   .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CPU_ACK_I(CPU_ACK_I),
   .CPU_IRQ_O(CPU_IRQ_O), .CPU_VECTOR_O(CPU_VECTOR_O), .CPU_SRC_O(CPU_SRC_O));

/* dv/core_model.sv */
`timescale 1ns/100ps
module core_model
(
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       irq_i,
   input  wire logic       en_i,
   input  wire logic [1:0] delay_i,
   output logic            ack_o
);
   logic [1:0] wait_reg;
   // Takes the vector after a chosen delay, one pulse per request
   always_ff @(posedge clk_i)
   begin
      ack_o    <= 1'b0;
      wait_reg <= 2'h0;
      if (rst_n_i && irq_i && en_i && !ack_o)
      begin
         wait_reg <= wait_reg + 2'h1;
         ack_o    <= wait_reg == delay_i;
      end
   end
endmodule

/* dv/testbench.sv */
`timescale 1ns/100ps
module testbench import irq_vec_pkg::*;;
   logic        clk, rst_n, psel, penable, pwrite, e, ack, core_en, wd_ovf;
   logic        wd_mode, cpu_irq, pready, pslverr, irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [17:0] single_ev;
   logic [7:0]  ev [9];
   logic [3:0]  ex;
   logic [1:0]  core_dly;
   logic [15:0] cpu_vec;
   logic [4:0]  cpu_src;
   int          n_fail, checks, seed, k, s;
   irq_vec_ctrl irq_vec_ctrl_inst (.CLK_SYS_I(clk), .RST_N_I(rst_n),
      .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .SINGLE_EVENT_I(single_ev), .PORT0_EVENT_I(ev[0]),
      .USB_RESUME_I(ex[1]), .PORT1_EVENT_I(ev[1]), .PORT2_EVENT_I(ev[2]),
      .USB_PENDING_I(ex[0]), .DMA_EVENT_I(ev[3]), .TIMER_ONE_EVENT_I(ev[4]),
      .TIMER_TWO_EVENT_I(ev[5]), .TIMER_THREE_EVENT_I(ev[6]),
      .TIMER_FOUR_EVENT_I(ev[7]), .RADIO_EVENT_I(ev[8]), .AUDIO_RX_I(ex[2]),
      .AUDIO_TX_I(ex[3]), .WATCHDOG_OVF_I(wd_ovf),
      .WATCHDOG_TIMER_MODE_I(wd_mode), .CPU_ACK_I(ack), .CPU_IRQ_O(cpu_irq),
      .CPU_VECTOR_O(cpu_vec), .CPU_SRC_O(cpu_src), .IRQ_O(irq));
   core_model core_model_inst (.clk_i(clk), .rst_n_i(rst_n), .irq_i(cpu_irq),
      .en_i(core_en), .delay_i(core_dly), .ack_o(ack));
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge clk);
         n++;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20)
      begin
         n_fail++;
         final_report;
      end
   endtask
   task wait_irq;
      int n;
      n = 0;
      while (cpu_irq !== 1'b1 && n < 50)
      begin
         @(posedge clk);
         n++;
      end
      if (n >= 50)
      begin
         n_fail++;
         final_report;
      end
   endtask
   // Codes below 9 are peripheral event groups, 9-12 extra lines, 13-30 single sources, 31 watchdog
   task pulse(input int k);
      @(posedge clk);
      if (k < 9)
         ev[k] <= 8'($random(seed)) | 8'h01;
      else if (k < 13)
         ex[k-9] <= 1'b1;
      else if (k < 31)
         single_ev[k-13] <= 1'b1;
      else
         wd_ovf <= 1'b1;
      cyc(2);
      foreach (ev[i])
         ev[i] <= 8'h00;
      ex <= 4'h0;
      single_ev <= 18'h00000;
      wd_ovf <= 1'b0;
   endtask
   function automatic int flag_bit(input int k);
      int t[13] = '{13, 15, 6, 8, 9, 10, 11, 12, 16, 6, 13, 3, 14};
      return t[k];
   endfunction
   function automatic int pick(input int i);
      int t[5] = '{1, 2, 4, 5, 7};
      return t[i];
   endfunction
   function automatic logic self_clear(input int s);
      return s <= 3 || (s >= 9 && s <= 12);
   endfunction
   task vec_case(input int k, input int s);
      apb(1'b1, ADDR_ENABLE, 32'h0);
      apb(1'b1, ADDR_FLAG, 32'h3ffff);
      pulse(k);
      apb(1'b1, ADDR_ENABLE, (32'h1 << s) | 32'h8000_0000);
      wait_irq;
      chk(cpu_vec, 32'(8 * s + 3));
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      {rst_n, psel, penable, pwrite, core_en, wd_ovf, wd_mode} = 7'h00;
      {paddr, pwdata, single_ev, ex, core_dly} = '0;
      foreach (ev[i])
         ev[i] = 8'h00;
      seed = 66442;
      cyc(20);
      rst_n <= 1'b1;
      apb(1'b0, ADDR_ENABLE, 32'h0);
      chk(q, 32'h0);
      apb(1'b0, ADDR_FLAG, 32'h0);
      chk(q, 32'h0);
      chk(cpu_vec, 32'h0003);
      apb(1'b0, 12'h020, 32'h0);
      chk(e, 1'b1);
      $display("test reset done");
      repeat (6)
      begin
         s = pick(int'($unsigned($random(seed)) % 5));
         apb(1'b1, ADDR_FLAG, 32'h3ffff);
         apb(1'b1, ADDR_ENABLE, 32'h8000_0000);
         pulse(s + 13);
         cyc(4);
         chk(cpu_irq, 1'b0);
         apb(1'b1, ADDR_ENABLE, 32'h1 << s);
         cyc(4);
         chk(cpu_irq, 1'b0);
         apb(1'b1, ADDR_ENABLE, (32'h1 << s) | 32'h8000_0000);
         wait_irq;
         chk(cpu_vec, 32'(8 * s + 3));
         chk(cpu_src, 32'(s));
         core_dly <= 2'($random(seed));
         core_en <= 1'b1;
         cyc(8);
         core_en <= 1'b0;
         apb(1'b1, ADDR_ENABLE, 32'h0);
         apb(1'b0, ADDR_FLAG, 32'h0);
         chk(q[s], !self_clear(s));
      end
      $display("test single sources done");
      apb(1'b1, ADDR_FLAG, 32'h3ffff);
      pulse(18);
      pulse(15);
      apb(1'b1, ADDR_ENABLE, 32'h8000_0024);
      wait_irq;
      chk(cpu_vec, 32'h0013);
      apb(1'b1, ADDR_ENABLE, 32'h0);
      apb(1'b1, ADDR_PRIO, 32'h0000_0c00);
      apb(1'b1, ADDR_ENABLE, 32'h8000_0024);
      wait_irq;
      chk(cpu_vec, 32'h002b);
      apb(1'b1, ADDR_PRIO, 32'h0);
      apb(1'b1, ADDR_ENABLE, 32'h0);
      apb(1'b1, ADDR_PMASK, 32'hf000_0000);
      apb(1'b1, ADDR_FLAG, 32'h3ffff);
      pulse(3);
      pulse(31);
      apb(1'b0, ADDR_FLAG, 32'h0);
      chk(q[8], 1'b0);
      chk(q[17], 1'b0);
      apb(1'b1, ADDR_PMASK, 32'hffff_ffff);
      wd_mode <= 1'b1;
      for (k = 0; k < 13; k++)
      begin
         apb(1'b1, ADDR_FLAG, 32'h3ffff);
         pulse(k);
         apb(1'b0, ADDR_FLAG, 32'h0);
         chk(q[flag_bit(k)], 1'b1);
      end
      vec_case(3, SRC_DMA);
      vec_case(5, SRC_TIMER_TWO);
      vec_case(10, 13);
      vec_case(31, SRC_WATCHDOG);
      apb(1'b1, ADDR_ENABLE, 32'h0);
      apb(1'b1, ADDR_FLAG, 32'h3ffff);
      apb(1'b1, ADDR_SWSET, 32'h0000_0010);
      apb(1'b0, ADDR_FLAG, 32'h0);
      chk(q, 32'h0000_0010);
      apb(1'b1, ADDR_PMASK, 32'h8000_005a);
      apb(1'b0, ADDR_PMASK, 32'h0);
      chk(q, 32'h8000_005a);
      $display("test events done");
      apb(1'b1, ADDR_IRQMASK, 32'h0);
      apb(1'b1, ADDR_IRQSTAT, 32'hffff_ffff);
      apb(1'b0, 12'h024, 32'h0);
      cyc(2);
      chk(irq, 1'b0);
      apb(1'b1, ADDR_IRQMASK, 32'hffff_ffff);
      cyc(2);
      chk(irq, 1'b1);
      apb(1'b1, ADDR_IRQSTAT, 32'hffff_ffff);
      cyc(2);
      chk(irq, 1'b0);
      $display("test status line done");
      final_report;
   end
endmodule
